// ===== design/tsl_pkg.sv
package tsl_pkg;

  // Clock and processing interval
  localparam int CLK_HZ = 10_000_000;
  localparam int SYS_FREQ_HZ = 60;
  localparam int PASSES_PER_CYCLE = 4;
  localparam int INTERVAL_CYCLES = CLK_HZ / (SYS_FREQ_HZ * PASSES_PER_CYCLE);
  localparam int CNT_W = 16;

  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_TERM_EN = 8'h04;
  localparam logic [7:0] ADDR_CMD = 8'h08;
  localparam logic [7:0] ADDR_STATE = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_STS = 8'h10;
  localparam logic [7:0] ADDR_IRQ_CLR = 8'h14;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h18;

  // Control register layout
  localparam int CTRL_W = 5;
  localparam int CTRL_LATCH = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam int CTRL_MODE_MSB = 2;
  localparam int CTRL_TQ_PHASE = 3;
  localparam int CTRL_TQ_GROUND = 4;
  localparam logic [CTRL_W-1:0] CTRL_RST = 5'h18;
  localparam int CMD_TGT_RESET = 0;

  // Trip equation product terms
  localparam int T_Z1P = 0;
  localparam int T_Z1G = 1;
  localparam int T_Z2P = 2;
  localparam int T_Z2G = 3;
  localparam int T_RES = 4;
  localparam int T_NEG = 5;
  localparam int T_INST = 6;
  localparam int T_DPH = 7;
  localparam int T_GND = 8;
  localparam int NUM_TERMS = 9;
  localparam logic [NUM_TERMS-1:0] TERM_EN_RST = 9'h1FF;

  // State register layout
  localparam int STS_TRIP = 0;
  localparam int STS_GATED = 1;
  localparam int STS_SEAL = 2;
  localparam int STS_BKR = 3;
  localparam int STS_IND = 4;
  localparam int STS_SH0 = 5;
  localparam int STS_W = 6;

  // Interrupt events
  localparam int IRQ_TRIP = 0;
  localparam int IRQ_SEAL = 1;
  localparam int IRQ_TGT = 2;
  localparam int IRQ_W = 3;

  localparam int SHOT_W = 3;
  localparam logic [SHOT_W-1:0] SHOT_ZERO = 3'h0;

  typedef enum logic [1:0] {
    TSL_MODE_EXPR = 2'h0,
    TSL_MODE_ONE = 2'h1,
    TSL_MODE_ZERO = 2'h2
  } tsl_mode_t;

  typedef struct packed {
    logic zone1_phase_distance_flag;
    logic zone1_ground_distance_flag;
    logic zone2_phase_distance_timed_flag;
    logic zone2_ground_distance_timed_flag;
    logic residual_ground_toc_timeout;
    logic neg_seq_toc_timeout;
    logic phase_inst_overcurrent_flag;
    logic directional_phase_oc_timed;
    logic directional_ground_oc_timed;
    logic phase_oc_torque_control;
    logic ground_oc_torque_control;
    logic target_reset_button;
  } tsl_flags_t;

endpackage

// ===== design/tsl_trip_logic.sv
// Added by the designer: the AHB-Lite register port and the register offsets.
`timescale 1ns/10ps
// Function
// - All AND products are formed before the OR combines them.
// - The phase instantaneous term counts only at reclose shot zero.
// - In expression mode the trip bit asserts whenever any enabled OR term is true.
// - The breaker trip contact follows the trip bit directly.
// - A constant-one equation always asserts, a constant-zero never.
// - Torque at constant one leaves only the directional qualifier.
// - Each pass does gated ground, seal-in, trip, then contacts.
// - After reset the gated ground and seal-in variables are zero.
// - Gated ground is the timed directional ground flag AND ground torque AND the latch.
// - The seal-in variable holds itself until target reset asserts.
// - The seal-in set term uses the last trip and lasts one pass.
// - With trip already set, a rising gated ground sets no seal-in.
// - The target reset pushbutton asserts the target reset bit.
// - Equations are evaluated every quarter cycle and hold between.
module tsl_trip_logic #(
  parameter int INTERVAL_CYCLES = tsl_pkg::INTERVAL_CYCLES
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Protection element pins
  input wire tsl_pkg::tsl_flags_t flags_i,
  input wire logic [tsl_pkg::SHOT_W-1:0] reclose_shot_count,
  // Contacts and interrupt
  output logic breaker_trip_contact,
  output logic ground_trip_indicator_contact,
  output logic irq
);

  typedef struct packed {
    tsl_pkg::tsl_flags_t sync1;
    tsl_pkg::tsl_flags_t sync2;
    logic [tsl_pkg::SHOT_W-1:0] shot1;
    logic [tsl_pkg::SHOT_W-1:0] shot2;
    logic [tsl_pkg::SHOT_W-1:0] shot3;
    logic [tsl_pkg::CNT_W-1:0] cnt;
    logic btn_prev;
    logic tgt_pend;
    logic trip;
    logic gated;
    logic sealin;
    logic bkr;
    logic ind;
    logic [tsl_pkg::CTRL_W-1:0] ctrl;
    logic [tsl_pkg::NUM_TERMS-1:0] term_en;
    logic [tsl_pkg::IRQ_W-1:0] irq_sts;
    logic [tsl_pkg::IRQ_W-1:0] irq_en;
    logic aph_valid;
    logic aph_write;
    logic [7:0] aph_addr;
    logic [31:0] rdata;
  } tsl_state_t;

  tsl_state_t st_q;
  tsl_state_t st_d;

  logic tick;
  logic sh0;
  logic tq_p;
  logic tq_g;
  logic tgt;
  logic gated_v;
  logic seal_set;
  logic sealin_v;
  logic trip_v;
  logic aph;
  logic [tsl_pkg::NUM_TERMS-1:0] prod;
  logic [tsl_pkg::IRQ_W-1:0] events;
  tsl_pkg::tsl_mode_t mode;

  // A counter word may skew through the flops; two zero samples mask it
  function automatic logic shot_zero(input tsl_state_t s);
    return (s.shot2 == tsl_pkg::SHOT_ZERO) &&
           (s.shot3 == tsl_pkg::SHOT_ZERO);
  endfunction

  function automatic logic wr_hit(input tsl_state_t s,
                                  input logic [7:0] a);
    return s.aph_valid && s.aph_write && (s.aph_addr == a);
  endfunction

  function automatic logic [31:0] rd_word(input logic [7:0] a,
                                          input tsl_state_t s);
    logic [31:0] w;
    w = 32'h0;
    case (a)
      tsl_pkg::ADDR_CTRL: w = {27'h0, s.ctrl};
      tsl_pkg::ADDR_TERM_EN: w = {23'h0, s.term_en};
      tsl_pkg::ADDR_STATE:
      begin
        w[tsl_pkg::STS_TRIP] = s.trip;
        w[tsl_pkg::STS_GATED] = s.gated;
        w[tsl_pkg::STS_SEAL] = s.sealin;
        w[tsl_pkg::STS_BKR] = s.bkr;
        w[tsl_pkg::STS_IND] = s.ind;
        w[tsl_pkg::STS_SH0] = shot_zero(s);
      end
      tsl_pkg::ADDR_IRQ_STS: w = {29'h0, s.irq_sts};
      tsl_pkg::ADDR_IRQ_EN: w = {29'h0, s.irq_en};
      default: w = 32'h0;
    endcase
    return w;
  endfunction

  always_comb
  begin
    st_d = st_q;
    // Pin synchronisers; first stage feeds only the second
    st_d.sync1 = flags_i;
    st_d.sync2 = st_q.sync1;
    st_d.shot1 = reclose_shot_count;
    st_d.shot2 = st_q.shot1;
    st_d.shot3 = st_q.shot2;
    st_d.btn_prev = st_q.sync2.target_reset_button;

    // Quarter-cycle pass timer
    tick = (st_q.cnt == tsl_pkg::CNT_W'(INTERVAL_CYCLES - 1));
    st_d.cnt = tick ? '0 : st_q.cnt + tsl_pkg::CNT_W'(1);

    mode = tsl_pkg::tsl_mode_t'(
      st_q.ctrl[tsl_pkg::CTRL_MODE_MSB:tsl_pkg::CTRL_MODE_LSB]);
    sh0 = shot_zero(st_q);
    // Torque control is either constant one or a pin; zero is not encodable
    tq_p = st_q.ctrl[tsl_pkg::CTRL_TQ_PHASE] |
           st_q.sync2.phase_oc_torque_control;
    tq_g = st_q.ctrl[tsl_pkg::CTRL_TQ_GROUND] |
           st_q.sync2.ground_oc_torque_control;
    tgt = st_q.tgt_pend | st_q.sync2.target_reset_button;

    // Pass order: gated ground, seal-in, trip, contacts
    gated_v = st_q.sync2.directional_ground_oc_timed & tq_g &
              st_q.ctrl[tsl_pkg::CTRL_LATCH];
    seal_set = gated_v & ~st_q.trip;
    sealin_v = seal_set | (st_q.sealin & ~tgt);

    // Products first, OR afterwards
    prod = '0;
    prod[tsl_pkg::T_Z1P] = st_q.sync2.zone1_phase_distance_flag;
    prod[tsl_pkg::T_Z1G] = st_q.sync2.zone1_ground_distance_flag;
    prod[tsl_pkg::T_Z2P] = st_q.sync2.zone2_phase_distance_timed_flag;
    prod[tsl_pkg::T_Z2G] = st_q.sync2.zone2_ground_distance_timed_flag;
    prod[tsl_pkg::T_RES] = st_q.sync2.residual_ground_toc_timeout;
    prod[tsl_pkg::T_NEG] = st_q.sync2.neg_seq_toc_timeout;
    prod[tsl_pkg::T_INST] = st_q.sync2.phase_inst_overcurrent_flag &
                            sh0;
    prod[tsl_pkg::T_DPH] = st_q.sync2.directional_phase_oc_timed & tq_p;
    prod[tsl_pkg::T_GND] = gated_v;

    // Unused mode code falls back to the expression so nothing is blank
    case (mode)
      tsl_pkg::TSL_MODE_ONE: trip_v = 1'b1;
      tsl_pkg::TSL_MODE_ZERO: trip_v = 1'b0;
      default: trip_v = |(prod & st_q.term_en);
    endcase

    events = '0;
    if (tick)
    begin
      st_d.gated = gated_v;
      st_d.sealin = sealin_v;
      st_d.trip = trip_v;
      st_d.bkr = trip_v;
      st_d.ind = sealin_v;
      st_d.tgt_pend = 1'b0;
      events[tsl_pkg::IRQ_TRIP] = trip_v & ~st_q.trip;
      events[tsl_pkg::IRQ_SEAL] = sealin_v & ~st_q.sealin;
      events[tsl_pkg::IRQ_TGT] = tgt & st_q.sealin & ~sealin_v;
    end

    // Press edge is held until the next pass consumes it
    if (st_q.sync2.target_reset_button & ~st_q.btn_prev)
    begin
      st_d.tgt_pend = 1'b1;
    end

    // AHB data phase writes
    if (st_q.aph_valid && st_q.aph_write)
    begin
      case (st_q.aph_addr)
        tsl_pkg::ADDR_CTRL: st_d.ctrl = hwdata[tsl_pkg::CTRL_W-1:0];
        tsl_pkg::ADDR_TERM_EN:
          st_d.term_en = hwdata[tsl_pkg::NUM_TERMS-1:0];
        tsl_pkg::ADDR_CMD:
        begin
          if (hwdata[tsl_pkg::CMD_TGT_RESET])
          begin
            st_d.tgt_pend = 1'b1;
          end
        end
        tsl_pkg::ADDR_IRQ_CLR:
          st_d.irq_sts = st_q.irq_sts & ~hwdata[tsl_pkg::IRQ_W-1:0];
        tsl_pkg::ADDR_IRQ_EN: st_d.irq_en = hwdata[tsl_pkg::IRQ_W-1:0];
        default: st_d.irq_en = st_d.irq_en;
      endcase
    end
    // New events win over a clear in the same cycle
    st_d.irq_sts = st_d.irq_sts | events;

    // AHB address phase
    aph = hsel & htrans[1] & hready;
    st_d.aph_valid = aph;
    st_d.aph_write = hwrite;
    st_d.aph_addr = haddr[7:0];
    st_d.rdata = (aph && !hwrite) ? rd_word(haddr[7:0], st_q) : 32'h0;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_q <= '0;
      st_q.ctrl <= tsl_pkg::CTRL_RST;
      st_q.term_en <= tsl_pkg::TERM_EN_RST;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = st_q.rdata;
  assign breaker_trip_contact = st_q.bkr;
  assign ground_trip_indicator_contact = st_q.ind;
  assign irq = |(st_q.irq_sts & st_q.irq_en);

  // Checks
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  localparam logic [tsl_pkg::NUM_TERMS-1:0] INST_MASK =
    {{(tsl_pkg::NUM_TERMS-1){1'b0}}, 1'b1} << tsl_pkg::T_INST;

  pass_hold_a: assert property (!tick |=> $stable(st_q.trip) &&
    $stable(st_q.sealin))
    else $error("trip state changed between passes");
  bkr_follow_a: assert property (
    breaker_trip_contact == st_q.trip)
    else $error("breaker contact differs from trip");
  ind_follow_a: assert property (
    ground_trip_indicator_contact == st_q.sealin)
    else $error("indicator contact differs from seal-in");
  or_any_a: assert property (tick &&
    mode == tsl_pkg::TSL_MODE_EXPR &&
    |(prod & st_q.term_en) |=> st_q.trip)
    else $error("enabled term did not trip");
  inst_gate_a: assert property (tick &&
    mode == tsl_pkg::TSL_MODE_EXPR && !sh0 &&
    ((prod | INST_MASK) & st_q.term_en) == (INST_MASK & st_q.term_en)
    |=> !st_q.trip)
    else $error("instantaneous term tripped past shot zero");
  const_one_a: assert property (tick &&
    mode == tsl_pkg::TSL_MODE_ONE |=> st_q.trip)
    else $error("constant one not asserted");
  const_zero_a: assert property (tick &&
    mode == tsl_pkg::TSL_MODE_ZERO |=> !st_q.trip)
    else $error("constant zero asserted");
  latch_block_a: assert property (tick &&
    !st_q.ctrl[tsl_pkg::CTRL_LATCH] && !st_q.sealin
    |=> !st_q.gated && !st_q.sealin)
    else $error("ground variables set with latch clear");
  same_pass_a: assert property (tick && gated_v &&
    mode == tsl_pkg::TSL_MODE_EXPR && st_q.term_en[tsl_pkg::T_GND]
    |=> st_q.trip && st_q.bkr)
    else $error("gated ground trip delayed");
  seal_hold_a: assert property (tick && st_q.sealin && !tgt
    |=> st_q.sealin)
    else $error("seal-in dropped without target reset");
  no_new_seal_a: assert property (tick && st_q.trip &&
    !st_q.sealin |=> !st_q.sealin)
    else $error("seal-in set while trip already set");
  torque_one_a: assert property (tick &&
    st_q.ctrl[tsl_pkg::CTRL_TQ_PHASE] &&
    st_q.sync2.directional_phase_oc_timed &&
    mode == tsl_pkg::TSL_MODE_EXPR && st_q.term_en[tsl_pkg::T_DPH]
    |=> st_q.trip)
    else $error("torque constant one blocked element");

  trip_rise_c: cover property (tick && !st_q.trip ##1 st_q.trip);
  seal_rise_c: cover property (tick && seal_set ##1 st_q.sealin);
  seal_clear_c: cover property (st_q.sealin ##[1:300]
    (tick && tgt) ##1 !st_q.sealin);
  const_mode_c: cover property (tick && mode == tsl_pkg::TSL_MODE_ONE);
  inst_block_c: cover property (tick && !sh0 &&
    st_q.sync2.phase_inst_overcurrent_flag);

  rst_clear_a: assert property ($rose(hresetn) |->
    !st_q.gated && !st_q.sealin && !breaker_trip_contact)
    else $error("ground variables not clear after reset");
  contact_hold_a: assert property (!tick |=>
    $stable(breaker_trip_contact) && $stable(ground_trip_indicator_contact))
    else $error("contact changed between passes");
  cnt_range_a: assert property (
    st_q.cnt < tsl_pkg::CNT_W'(INTERVAL_CYCLES))
    else $error("pass timer out of range");
  term_mask_a: assert property (tick &&
    mode == tsl_pkg::TSL_MODE_EXPR && (prod & st_q.term_en) == '0
    |=> !st_q.trip)
    else $error("trip without an enabled term");
  inst_pass_a: assert property (tick && sh0 &&
    st_q.sync2.phase_inst_overcurrent_flag &&
    mode == tsl_pkg::TSL_MODE_EXPR && st_q.term_en[tsl_pkg::T_INST]
    |=> st_q.trip)
    else $error("instantaneous term blocked at shot zero");
  gated_zero_a: assert property (tick &&
    !st_q.sync2.directional_ground_oc_timed |=> !st_q.gated)
    else $error("gated ground set without its element");
  seal_once_a: assert property (tick && seal_set &&
    mode == tsl_pkg::TSL_MODE_EXPR && st_q.term_en[tsl_pkg::T_GND]
    |=> st_q.sealin && st_q.trip)
    else $error("seal-in set term not followed by trip");
  ind_rise_a: assert property (
    $rose(ground_trip_indicator_contact) |-> $past(seal_set))
    else $error("indicator rose without the set term");
  seal_clear_a: assert property (tick && tgt && !seal_set
    |=> !st_q.sealin)
    else $error("target reset left seal-in set");
  tgt_press_a: assert property (st_q.sync2.target_reset_button &&
    !st_q.btn_prev |=> st_q.tgt_pend)
    else $error("target reset press lost");
  cmd_tgt_a: assert property (wr_hit(st_q, tsl_pkg::ADDR_CMD) &&
    hwdata[tsl_pkg::CMD_TGT_RESET] |=> st_q.tgt_pend)
    else $error("target reset command lost");
  irq_set_a: assert property (tick && trip_v && !st_q.trip
    |=> st_q.irq_sts[tsl_pkg::IRQ_TRIP])
    else $error("trip event not recorded");
  rdata_idle_a: assert property (!st_q.aph_valid || st_q.aph_write
    |-> hrdata == 32'h0)
    else $error("read data outside a read data phase");

endmodule

// ===== tb/tsl_elem_model.sv
`timescale 1ns/10ps
module tsl_elem_model (
  // Clock
  input wire logic hclk,
  // Element states asked for by the bench
  input wire tsl_pkg::tsl_flags_t want,
  input wire logic [tsl_pkg::SHOT_W-1:0] want_shot,
  // Pins toward the trip logic
  output tsl_pkg::tsl_flags_t flags_i,
  output logic [tsl_pkg::SHOT_W-1:0] shot
);
  initial flags_i = '0;
  initial shot = 3'h0;
  // Elements move only just after an edge and hold until the bench asks for new states
  always @(posedge hclk)
  begin
    flags_i <= want;
    shot <= want_shot;
  end
endmodule

// ===== tb/tsl_tb.sv
`timescale 1ns/10ps
module tb;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, bkr, ind, irq;
  logic [31:0] hrdata;
  tsl_pkg::tsl_flags_t want = '0;
  tsl_pkg::tsl_flags_t flags, f;
  logic [2:0] want_shot = 3'h0;
  logic [2:0] shot;
  logic rd_ph = 1'b0;
  logic [31:0] q[$];
  logic [31:0] r = 32'hC427917F;
  logic tr;
  int n_mismatch = 0;
  int checks = 0;

  always #50 hclk = ~hclk;

  tsl_elem_model elem (.hclk(hclk), .want(want), .want_shot(want_shot),
    .flags_i(flags), .shot(shot));

  tsl_trip_logic #(.INTERVAL_CYCLES(16)) dut (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .flags_i(flags), .reclose_shot_count(shot),
    .breaker_trip_contact(bkr), .ground_trip_indicator_contact(ind),
    .irq(irq));

  function automatic logic [31:0] lfsr(input logic [31:0] v);
    lfsr = {v[30:0], 1'b0} ^ (v[31] ? 32'h04C11DB7 : 32'h0);
  endfunction

  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    cmp_word({31'h0, got}, {31'h0, exp});
  endtask

  // Single word transfer; a read notes its expected data in the queue
  task automatic ahb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    if (w)
      hwdata <= d;
    else
      q.push_back(d);
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask

  // Data phase of a read: compare against the oldest note
  always @(posedge hclk)
  begin
    if (rd_ph && q.size() > 0)
    begin
      cmp_word(hrdata, q.pop_front());
      cmp_bit(hresp, 1'b0);
    end
    rd_ph <= hsel && htrans[1] && !hwrite && hreadyout === 1'b1;
  end

  // 40 cycles: sync latency plus two full intervals of 16
  task automatic pass_wait();
    repeat (40) @(posedge hclk);
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    #(100 * 30000);
    n_mismatch++;
    end_sim();
  end

  initial
  begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, tsl_pkg::ADDR_CTRL, 32'h18);
    ahb(1'b0, tsl_pkg::ADDR_TERM_EN, 32'h1FF);
    ahb(1'b0, tsl_pkg::ADDR_STATE, 32'h20);
    ahb(1'b0, 8'h1C, 32'h0);
    $display("test reset values done");
    // Random element mixes, gated ground kept out
    for (int i = 0; i < 12; i++)
    begin
      r = lfsr(r);
      f = r[11:0];
      f.directional_ground_oc_timed = 1'b0;
      f.target_reset_button = 1'b0;
      want_shot <= r[14:12] & {3{r[15]}};
      tr = f.zone1_phase_distance_flag | f.zone1_ground_distance_flag |
        f.zone2_phase_distance_timed_flag | f.residual_ground_toc_timeout |
        f.zone2_ground_distance_timed_flag | f.neg_seq_toc_timeout |
        (f.phase_inst_overcurrent_flag & !(r[15] && r[14:12] != 3'h0)) |
        f.directional_phase_oc_timed;
      want <= f;
      pass_wait();
      ahb(1'b0, tsl_pkg::ADDR_STATE, {26'h0, !(r[15] && r[14:12] != 3'h0),
        1'b0, tr, 2'h0, tr});
      cmp_bit(bkr, tr);
    end
    f = '0;
    f.phase_inst_overcurrent_flag = 1'b1;
    want <= f;
    want_shot <= 3'h1;
    pass_wait();
    ahb(1'b0, tsl_pkg::ADDR_STATE, 32'h0);
    want <= '0;
    want_shot <= 3'h0;
    $display("test trip terms done");
    // Trip equation set to constant one, then constant zero
    ahb(1'b1, tsl_pkg::ADDR_CTRL, 32'h1A);
    pass_wait();
    ahb(1'b0, tsl_pkg::ADDR_STATE, 32'h29);
    ahb(1'b1, tsl_pkg::ADDR_CTRL, 32'h1C);
    want.zone1_phase_distance_flag <= 1'b1;
    pass_wait();
    ahb(1'b0, tsl_pkg::ADDR_STATE, 32'h20);
    // Spare mode code evaluates the expression
    ahb(1'b1, tsl_pkg::ADDR_CTRL, 32'h1E);
    pass_wait();
    ahb(1'b0, tsl_pkg::ADDR_STATE, 32'h29);
    // Phase torque follows a low pin: element stays quiet
    ahb(1'b1, tsl_pkg::ADDR_CTRL, 32'h10);
    f = '0;
    f.directional_phase_oc_timed = 1'b1;
    want <= f;
    pass_wait();
    ahb(1'b0, tsl_pkg::ADDR_STATE, 32'h20);
    want <= '0;
    $display("test constants done");
    // Latch clear blocks gated ground and seal-in
    ahb(1'b1, tsl_pkg::ADDR_CTRL, 32'h18);
    want.directional_ground_oc_timed <= 1'b1;
    pass_wait();
    ahb(1'b0, tsl_pkg::ADDR_STATE, 32'h20);
    ahb(1'b1, tsl_pkg::ADDR_CTRL, 32'h19);
    ahb(1'b1, tsl_pkg::ADDR_IRQ_EN, 32'h7);
    pass_wait();
    ahb(1'b0, tsl_pkg::ADDR_STATE, 32'h3F);
    ahb(1'b0, tsl_pkg::ADDR_IRQ_STS, 32'h3);
    cmp_bit(ind, 1'b1);
    cmp_bit(irq, 1'b1);
    ahb(1'b1, tsl_pkg::ADDR_IRQ_CLR, 32'h7);
    ahb(1'b0, tsl_pkg::ADDR_IRQ_STS, 32'h0);
    cmp_bit(irq, 1'b0);
    want <= '0;
    pass_wait();
    ahb(1'b0, tsl_pkg::ADDR_STATE, 32'h34);
    cmp_bit(bkr, 1'b0);
    want.target_reset_button <= 1'b1;
    repeat (4) @(posedge hclk);
    want <= '0;
    pass_wait();
    ahb(1'b0, tsl_pkg::ADDR_STATE, 32'h20);
    ahb(1'b0, tsl_pkg::ADDR_IRQ_STS, 32'h4);
    cmp_bit(ind, 1'b0);
    ahb(1'b1, tsl_pkg::ADDR_IRQ_CLR, 32'h7);
    ahb(1'b1, tsl_pkg::ADDR_IRQ_EN, 32'h0);
    $display("test seal-in done");
    // Phase trip first, ground rises later
    want.directional_phase_oc_timed <= 1'b1;
    pass_wait();
    want.directional_ground_oc_timed <= 1'b1;
    pass_wait();
    ahb(1'b0, tsl_pkg::ADDR_STATE, 32'h2B);
    want <= '0;
    ahb(1'b1, tsl_pkg::ADDR_CMD, 32'h1);
    pass_wait();
    ahb(1'b0, tsl_pkg::ADDR_STATE, 32'h20);
    $display("test trip before ground done");
    end_sim();
  end
endmodule
